// File: rtl/gdc_pkg.sv
// Purpose: Shared constants for the gate-driver configuration register bank
// Assumes: 20 MHz system clock, APB with 32-bit data and word-aligned registers
// Notes: Printed offsets are register indices; byte address is four times the index
package gdc_pkg;

  // Register indices and byte addresses
  localparam logic [9:0] GDC_IDX_CFG_ONE = 10'h0AC;
  localparam logic [9:0] GDC_IDX_CFG_TWO = 10'h0AE;
  localparam logic [9:0] GDC_IDX_IRQ_STATUS = 10'h0B0;
  localparam logic [9:0] GDC_IDX_IRQ_MASK = 10'h0B2;
  localparam logic [9:0] GDC_IDX_FAULT_CTRL = 10'h0B4;
  localparam int GDC_ADDR_W = 12;
  localparam logic [GDC_ADDR_W-1:0] GDC_ADDR_CFG_ONE = {GDC_IDX_CFG_ONE, 2'h0};
  localparam logic [GDC_ADDR_W-1:0] GDC_ADDR_CFG_TWO = {GDC_IDX_CFG_TWO, 2'h0};
  localparam logic [GDC_ADDR_W-1:0] GDC_ADDR_IRQ_STATUS = {GDC_IDX_IRQ_STATUS, 2'h0};
  localparam logic [GDC_ADDR_W-1:0] GDC_ADDR_IRQ_MASK = {GDC_IDX_IRQ_MASK, 2'h0};
  localparam logic [GDC_ADDR_W-1:0] GDC_ADDR_FAULT_CTRL = {GDC_IDX_FAULT_CTRL, 2'h0};

  // Reset values
  localparam logic [31:0] GDC_RST_CFG_ONE = 32'h10228100;
  localparam logic [31:0] GDC_RST_CFG_TWO = 32'h01200000;

  // First word fields
  localparam int GDC_F1_RETRY_TIME = 11;
  localparam int GDC_F1_OC_THRESH = 10;
  localparam int GDC_F1_OC_MODE_LO = 8;
  localparam int GDC_F1_GAIN_LO = 0;

  // Second word fields
  localparam int GDC_F2_DELAY_COMP = 30;
  localparam int GDC_F2_TDELAY_LO = 26;
  localparam int GDC_F2_REG_SLEW = 25;
  localparam int GDC_F2_REG_SEQ_OFF = 24;
  localparam int GDC_F2_REG_CLIM = 23;
  localparam int GDC_F2_REG_VSEL_LO = 21;
  localparam int GDC_F2_REG_DIS = 20;

  // Interrupt status / mask bits
  localparam int GDC_IRQ_BITS = 2;
  localparam int GDC_IRQ_OC_REPORT = 0;
  localparam int GDC_IRQ_RETRY_DONE = 1;

  // Fault control bits
  localparam int GDC_FC_ACTIVE = 0;
  localparam int GDC_FC_RETRY_WAIT = 1;

  typedef enum logic [1:0] {
    GDC_OC_LATCHED = 2'h0,
    GDC_OC_RETRY = 2'h1,
    GDC_OC_REPORT = 2'h2,
    GDC_OC_IGNORE = 2'h3
  } gdc_oc_mode_e;

  // Retry waits
  localparam longint GDC_CLK_HZ = 20000000;
  localparam longint GDC_RETRY_SHORT_MS = 5;
  localparam longint GDC_RETRY_LONG_MS = 500;
  localparam int GDC_TIMER_W = 24;
  localparam int GDC_RETRY_SHORT_CYC = int'(GDC_RETRY_SHORT_MS * GDC_CLK_HZ / 1000);
  localparam int GDC_RETRY_LONG_CYC = int'(GDC_RETRY_LONG_MS * GDC_CLK_HZ / 1000);

endpackage : gdc_pkg

// File: rtl/gdc_sync.sv
// Purpose: Two-stage synchroniser for asynchronous level inputs
// Assumes: Inputs are slow levels; pulses shorter than one clock may be missed
// Notes: Stage one feeds only stage two
`timescale 1ns/1ns
`default_nettype none
module gdc_sync #(
  parameter int W = 1
) (
  input wire logic mclk, // System clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic mclkEn, // Clock enable
  input wire logic [W-1:0] asyncIn, // Unsynchronised level
  output logic [W-1:0] syncOut // Synchronised level
);
  typedef struct packed {
    logic [W-1:0] stageOne;
    logic [W-1:0] stageTwo;
  } gdc_sync_s;

  gdc_sync_s st_q;
  gdc_sync_s st_d;

  always_comb begin
    st_d = st_q;
    if (mclkEn) begin
      st_d.stageOne = asyncIn;
      st_d.stageTwo = st_q.stageOne;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign syncOut = st_q.stageTwo;
endmodule : gdc_sync
`default_nettype wire

// File: rtl/gdc_oc_fault.sv
// Purpose: Overcurrent fault handling per selected fault mode
// Assumes: ocLevel is already synchronised to mclk
// Notes: Mode of a fault in progress is kept even if software changes it
`timescale 1ns/1ns
`default_nettype none
module gdc_oc_fault
  import gdc_pkg::*;
#(
  parameter int RETRY_SHORT = GDC_RETRY_SHORT_CYC,
  parameter int RETRY_LONG = GDC_RETRY_LONG_CYC
) (
  input wire logic mclk, // System clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic mclkEn, // Clock enable
  input wire logic ocLevel, // Overcurrent detected, synchronised level
  input wire gdc_pkg::gdc_oc_mode_e faultMode, // Overcurrent fault mode
  input wire logic retryLong, // Selects long retry wait
  input wire logic clearLatched, // One-cycle request to clear a latched fault
  output logic faultActive, // Protective shutdown active
  output logic retryWait, // Waiting out a retry interval
  output logic reportPulse, // Overcurrent reported, one cycle
  output logic retryDonePulse // Fault cleared by retry, one cycle
);
  typedef struct packed {
    logic ocPrev;
    logic active;
    logic retrying;
    logic [GDC_TIMER_W-1:0] timer;
    logic report;
    logic retryDone;
  } gdc_fault_s;

  gdc_fault_s st_q;
  gdc_fault_s st_d;
  logic ocEvent;

  assign ocEvent = ocLevel && !st_q.ocPrev;

  always_comb begin
    st_d = st_q;
    if (mclkEn) begin
      st_d.ocPrev = ocLevel;
      st_d.report = 1'b0;
      st_d.retryDone = 1'b0;
      if (st_q.active && st_q.retrying) begin
        if (st_q.timer <= GDC_TIMER_W'(1)) begin
          st_d.active = 1'b0;
          st_d.retrying = 1'b0;
          st_d.timer = '0;
          st_d.retryDone = 1'b1;
        end else begin
          st_d.timer = st_q.timer - GDC_TIMER_W'(1);
        end
      end
      if (clearLatched && st_q.active && !st_q.retrying) begin
        st_d.active = 1'b0;
      end
      if (ocEvent) begin
        unique case (faultMode)
          GDC_OC_LATCHED: begin
            st_d.active = 1'b1;
            st_d.retrying = 1'b0;
            st_d.timer = '0;
            st_d.report = 1'b1;
          end
          GDC_OC_RETRY: begin
            st_d.active = 1'b1;
            st_d.retrying = 1'b1;
            st_d.timer = retryLong ? GDC_TIMER_W'(RETRY_LONG) : GDC_TIMER_W'(RETRY_SHORT);
            st_d.retryDone = 1'b0;
            st_d.report = 1'b1;
          end
          GDC_OC_REPORT: begin
            st_d.report = 1'b1;
          end
          GDC_OC_IGNORE: begin
            st_d.report = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign faultActive = st_q.active;
  assign retryWait = st_q.retrying;
  assign reportPulse = st_q.report;
  assign retryDonePulse = st_q.retryDone;
endmodule : gdc_oc_fault
`default_nettype wire

// File: rtl/gdc_regs.sv
// Purpose: APB register bank for gate-driver configuration and overcurrent handling
// Assumes: APB master holds the request until pready; one wait state per access
// Notes: Configuration fields drive the analog and driver blocks as plain levels
//
// Local design decision: the APB register port.
`timescale 1ns/1ns
`default_nettype none
module gdc_regs
  import gdc_pkg::*;
#(
  parameter int RETRY_SHORT = GDC_RETRY_SHORT_CYC,
  parameter int RETRY_LONG = GDC_RETRY_LONG_CYC
) (
  input wire logic mclk, // System clock, 20 MHz
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic mclkEn, // Clock enable, freezes state when low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [gdc_pkg::GDC_ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic ocDetectPin, // Overcurrent comparator, asynchronous
  output logic irq, // Level interrupt
  output logic driverShutdown, // Protective shutdown of the bridge
  output logic ocThresholdSel, // Overcurrent threshold select
  output logic [1:0] senseAmpGain, // Sense amplifier gain code
  output logic delayCompEnable, // Driver delay compensation enable
  output logic [3:0] targetDelay, // Target delay code
  output logic regulatorSlewSel, // Regulator switch slew select
  output logic regulatorSequencingOff, // Regulator power sequencing off
  output logic regulatorCurrentLimit, // Regulator current limit select
  output logic [1:0] regulatorVoltageSel, // Regulator voltage code
  output logic regulatorDisable // Regulator off
);
  typedef struct packed {
    logic [31:0] cfgOne;
    logic [31:0] cfgTwo;
    logic [GDC_IRQ_BITS-1:0] irqStatus;
    logic [GDC_IRQ_BITS-1:0] irqMask;
    logic irqOut;
    logic clrLatched;
    logic ready;
    logic slvErr;
    logic [31:0] rdata;
  } gdc_regs_s;

  gdc_regs_s st_q;
  gdc_regs_s st_d;

  logic ocSynced;
  logic faultActive;
  logic retryWait;
  logic reportPulse;
  logic retryDonePulse;
  logic accessReq;
  logic accessDone;
  logic addrMapped;
  logic [31:0] readMux;
  logic [31:0] strobeMask;
  logic [GDC_IRQ_BITS-1:0] irqEvents;
  logic [GDC_IRQ_BITS-1:0] irqClear;

  gdc_sync #(
    .W(1)
  ) u_oc_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .mclkEn(mclkEn),
    .asyncIn(ocDetectPin),
    .syncOut(ocSynced)
  );

  gdc_oc_fault #(
    .RETRY_SHORT(RETRY_SHORT),
    .RETRY_LONG(RETRY_LONG)
  ) u_oc_fault (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .mclkEn(mclkEn),
    .ocLevel(ocSynced),
    .faultMode(gdc_oc_mode_e'(st_q.cfgOne[GDC_F1_OC_MODE_LO +: 2])),
    .retryLong(st_q.cfgOne[GDC_F1_RETRY_TIME]),
    .clearLatched(st_q.clrLatched),
    .faultActive(faultActive),
    .retryWait(retryWait),
    .reportPulse(reportPulse),
    .retryDonePulse(retryDonePulse)
  );

  // Byte strobes widened to a bit mask
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      strobeMask[i*8 +: 8] = {8{pstrb[i]}};
    end
  end

  assign accessReq = psel && penable && !st_q.ready;
  assign accessDone = psel && penable && st_q.ready;

  // Address decode and read data
  always_comb begin
    addrMapped = 1'b1;
    readMux = 32'h00000000;
    unique case (paddr)
      GDC_ADDR_CFG_ONE: begin
        readMux = st_q.cfgOne;
      end
      GDC_ADDR_CFG_TWO: begin
        readMux = st_q.cfgTwo;
      end
      GDC_ADDR_IRQ_STATUS: begin
        readMux[GDC_IRQ_BITS-1:0] = st_q.irqStatus;
      end
      GDC_ADDR_IRQ_MASK: begin
        readMux[GDC_IRQ_BITS-1:0] = st_q.irqMask;
      end
      GDC_ADDR_FAULT_CTRL: begin
        readMux[GDC_FC_ACTIVE] = faultActive;
        readMux[GDC_FC_RETRY_WAIT] = retryWait;
      end
      default: begin
        addrMapped = 1'b0;
      end
    endcase
  end

  assign irqEvents = {retryDonePulse, reportPulse};

  always_comb begin
    st_d = st_q;
    irqClear = '0;
    if (mclkEn) begin
      st_d.clrLatched = 1'b0;
      // One wait state: answer is registered in the first access cycle
      if (accessReq) begin
        st_d.ready = 1'b1;
        st_d.slvErr = !addrMapped;
        st_d.rdata = pwrite ? 32'h00000000 : readMux;
      end
      if (accessDone) begin
        st_d.ready = 1'b0;
        st_d.slvErr = 1'b0;
        st_d.rdata = 32'h00000000;
        if (pwrite && addrMapped) begin
          unique case (paddr)
            // threshold, gain, retry time and mode all live here
            GDC_ADDR_CFG_ONE: begin
              st_d.cfgOne = (st_q.cfgOne & ~strobeMask) | (pwdata & strobeMask);
            end
            GDC_ADDR_CFG_TWO: begin
              st_d.cfgTwo = (st_q.cfgTwo & ~strobeMask) | (pwdata & strobeMask);
              st_d.cfgTwo[GDC_F2_REG_SEQ_OFF] = st_q.cfgTwo[GDC_F2_REG_SEQ_OFF]
                && !(pstrb[GDC_F2_REG_SEQ_OFF/8] && pwdata[GDC_F2_REG_SEQ_OFF]);
            end
            GDC_ADDR_IRQ_STATUS: begin
              if (pstrb[0]) begin
                irqClear = pwdata[GDC_IRQ_BITS-1:0];
              end
            end
            GDC_ADDR_IRQ_MASK: begin
              if (pstrb[0]) begin
                st_d.irqMask = pwdata[GDC_IRQ_BITS-1:0];
              end
            end
            GDC_ADDR_FAULT_CTRL: begin
              st_d.clrLatched = pstrb[0] && pwdata[GDC_FC_ACTIVE];
            end
            default: begin
              st_d.clrLatched = 1'b0;
            end
          endcase
        end
      end
      // Set wins over a simultaneous clear
      st_d.irqStatus = (st_q.irqStatus & ~irqClear) | irqEvents;
      st_d.irqOut = |(st_d.irqStatus & st_d.irqMask);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q.cfgOne <= GDC_RST_CFG_ONE;
      st_q.cfgTwo <= GDC_RST_CFG_TWO;
      st_q.irqStatus <= '0;
      st_q.irqMask <= '0;
      st_q.irqOut <= 1'b0;
      st_q.clrLatched <= 1'b0;
      st_q.ready <= 1'b0;
      st_q.slvErr <= 1'b0;
      st_q.rdata <= 32'h00000000;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.rdata;
  assign pready = st_q.ready;
  assign pslverr = st_q.slvErr;
  assign irq = st_q.irqOut;
  assign driverShutdown = faultActive;
  assign ocThresholdSel = st_q.cfgOne[GDC_F1_OC_THRESH];
  assign senseAmpGain = st_q.cfgOne[GDC_F1_GAIN_LO +: 2];
  assign delayCompEnable = st_q.cfgTwo[GDC_F2_DELAY_COMP];
  assign targetDelay = st_q.cfgTwo[GDC_F2_TDELAY_LO +: 4];
  assign regulatorSlewSel = st_q.cfgTwo[GDC_F2_REG_SLEW];
  assign regulatorSequencingOff = st_q.cfgTwo[GDC_F2_REG_SEQ_OFF];
  assign regulatorCurrentLimit = st_q.cfgTwo[GDC_F2_REG_CLIM];
  assign regulatorVoltageSel = st_q.cfgTwo[GDC_F2_REG_VSEL_LO +: 2];
  assign regulatorDisable = st_q.cfgTwo[GDC_F2_REG_DIS];
endmodule : gdc_regs
`default_nettype wire

// File: tb/gdc_regs_checker.sv
// Purpose: Port assertions for the gate-driver register bank
// Assumes: mclkEn never low during an APB transfer; compared config writes use all strobes
// Notes: Bound to gdc_regs from the bench top file
`timescale 1ns/1ns
`default_nettype none
module gdc_regs_checker
  import gdc_pkg::*;
#(
  parameter int RETRY_SHORT = 20,
  parameter int RETRY_LONG = 50
) (
  input wire logic mclk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic mclkEn, // Enable
  input wire logic psel, // Select
  input wire logic penable, // Access
  input wire logic pwrite, // Write
  input wire logic [gdc_pkg::GDC_ADDR_W-1:0] paddr, // Address
  input wire logic [31:0] pwdata, // Data
  input wire logic [3:0] pstrb, // Strobes
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic ocDetectPin, // Pin
  input wire logic driverShutdown, // Shutdown
  input wire logic ocThresholdSel, // Threshold
  input wire logic [1:0] senseAmpGain, // Gain
  input wire logic delayCompEnable, // Delay comp
  input wire logic [3:0] targetDelay, // Delay
  input wire logic regulatorSlewSel, // Slew
  input wire logic regulatorSequencingOff, // Sequencing
  input wire logic regulatorCurrentLimit, // Limit
  input wire logic [1:0] regulatorVoltageSel, // Voltage
  input wire logic regulatorDisable // Off
);
  logic [12:0] cfgView;
  logic mapped;
  logic cfgWr;
  assign cfgView = {ocThresholdSel, senseAmpGain, delayCompEnable, targetDelay,
    regulatorSlewSel, regulatorCurrentLimit, regulatorVoltageSel, regulatorDisable};
  assign mapped = paddr inside {GDC_ADDR_CFG_ONE, GDC_ADDR_CFG_TWO, GDC_ADDR_IRQ_STATUS,
    GDC_ADDR_IRQ_MASK, GDC_ADDR_FAULT_CTRL};
  assign cfgWr = psel && penable && pready && pwrite &&
    (paddr == GDC_ADDR_CFG_ONE || paddr == GDC_ADDR_CFG_TWO);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence s_done;
    psel && penable && pready && mclkEn;
  endsequence
  sequence s_wr(logic [11:0] a);
    s_done ##0 (pwrite && pstrb == 4'hF && paddr == a);
  endsequence
  chk_ready_wait: assert property (psel && penable && !pready && mclkEn |=> pready)
    else $error("Ready missing after wait state");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("Ready held too long");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("Read data outside answer cycle");
  chk_err_unmapped: assert property (s_done |-> pslverr == !mapped)
    else $error("Error flag does not match decode");
  chk_two_write: assert property (s_wr(GDC_ADDR_CFG_TWO) |=>
    cfgView[9:0] == $past({pwdata[30:25], pwdata[23:20]}))
    else $error("Second word fields not written");
  chk_one_write: assert property (s_wr(GDC_ADDR_CFG_ONE) |=>
    ocThresholdSel == $past(pwdata[10]) && senseAmpGain == $past(pwdata[1:0]))
    else $error("First word fields not written");
  chk_cfg_hold: assert property (!cfgWr |=> $stable(cfgView))
    else $error("Config changed without a write");
  chk_seq_sticky: assert property (!regulatorSequencingOff |=> !regulatorSequencingOff)
    else $error("Sequencing bit set again");
  chk_seq_clear: assert property (s_wr(GDC_ADDR_CFG_TWO) ##0 pwdata[24]
    |=> !regulatorSequencingOff)
    else $error("Sequencing bit not cleared");
  chk_reset_vals: assert property ($fell(sys_rst) |->
    cfgView == 13'h0002 && regulatorSequencingOff)
    else $error("Wrong config after reset");
  chk_shut_cause: assert property ($rose(driverShutdown) |-> $past(ocDetectPin, 2))
    else $error("Shutdown without overcurrent");
  chk_freeze_hold: assert property (!mclkEn |=> $stable(driverShutdown) &&
    $stable(cfgView) && $stable(pready) && $stable(regulatorSequencingOff))
    else $error("State moved while clock enable low");
endmodule : gdc_regs_checker
`default_nettype wire

// File: tb/gdc_regs_test.sv
// Purpose: Self-checking bench for the gate-driver register bank
// Assumes: One wait state per APB access; short retry counts
// Notes: Checker is bound at the foot of this file
`timescale 1ns/1ns
`default_nettype none
module gdc_regs_test;
  import gdc_pkg::*;
  localparam int RS = 20;
  localparam int RL = 50;
  logic mclk = 1'b0, sys_rst = 1'b1, mclkEn = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, ocDetectPin = 1'b0, pready, pslverr, irq, driverShutdown;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0] pstrb = 4'h0, targetDelay;
  logic ocThresholdSel, delayCompEnable, regulatorSlewSel, regulatorSequencingOff;
  logic regulatorCurrentLimit, regulatorDisable;
  logic [1:0] senseAmpGain, regulatorVoltageSel;
  int badCount = 0, checked = 0;
  gdc_regs #(.RETRY_SHORT(RS), .RETRY_LONG(RL)) i_gdc_regs (.mclk, .sys_rst, .mclkEn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .ocDetectPin, .irq, .driverShutdown, .ocThresholdSel, .senseAmpGain, .delayCompEnable,
    .targetDelay, .regulatorSlewSel, .regulatorSequencingOff, .regulatorCurrentLimit,
    .regulatorVoltageSel, .regulatorDisable);
  initial begin
    forever #25 mclk = ~mclk;
  end
  task automatic give_verdict;
    $display("Checks %0d, errors %0d", checked, badCount);
    if (badCount == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      badCount++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Setup, access until ready, then one idle cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      badCount++;
      $display("Error at %0t: no ready from the bus", $time);
      give_verdict();
    end
    @(posedge mclk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, 4'hF, r, e);
    chk(32'(e), 32'h0);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, 4'h0, r, e);
    chk(r, x);
  endtask : rd
  task automatic t_reset;
    rd(GDC_ADDR_CFG_ONE, 32'h10228100);
    rd(GDC_ADDR_CFG_TWO, 32'h01200000);
    chk(32'({ocThresholdSel, senseAmpGain, regulatorSequencingOff, regulatorVoltageSel}),
      32'h05);
  endtask : t_reset
  task automatic t_cfg_one;
    for (int k = 0; k < 4; k++) begin
      wr(GDC_ADDR_CFG_ONE, 32'h10228100 | 32'(k[0]) << 10 | 32'(k));
      chk(32'({ocThresholdSel, senseAmpGain}), 32'(k[0]) << 2 | 32'(k));
    end
  endtask : t_cfg_one
  task automatic t_cfg_two;
    wr(GDC_ADDR_CFG_TWO, 32'h7EF00000);
    rd(GDC_ADDR_CFG_TWO, 32'h7FF00000);
    chk(32'({delayCompEnable, targetDelay, regulatorSlewSel, regulatorCurrentLimit,
      regulatorVoltageSel, regulatorDisable}), 32'h3FF);
    wr(GDC_ADDR_CFG_TWO, 32'h05400000);
    rd(GDC_ADDR_CFG_TWO, 32'h04400000);
    chk(32'({delayCompEnable, targetDelay, regulatorSlewSel, regulatorCurrentLimit,
      regulatorVoltageSel, regulatorDisable}), 32'h024);
    for (int k = 0; k < 16; k++) begin
      wr(GDC_ADDR_CFG_TWO, 32'(k) << 26 | 32'h01000000);
      chk(32'(targetDelay), 32'(k));
    end
    rd(GDC_ADDR_CFG_TWO, 32'h3C000000);
  endtask : t_cfg_two
  task automatic t_unmapped;
    logic [31:0] r;
    logic e;
    apb(1'b0, 12'h004, 32'h0, 4'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    apb(1'b1, 12'h2B9, 32'hFFFFFFFF, 4'hF, r, e);
    chk(32'(e), 32'h1);
    rd(GDC_ADDR_CFG_TWO, 32'h3C000000);
  endtask : t_unmapped
  task automatic t_oc(input logic [1:0] m, input logic lng, input int wt);
    int n;
    wr(GDC_ADDR_IRQ_MASK, 32'h3);
    wr(GDC_ADDR_CFG_ONE, 32'h10228000 | 32'(lng) << 11 | 32'(m) << 8);
    ocDetectPin <= 1'b1;
    repeat (6) @(posedge mclk);
    ocDetectPin <= 1'b0;
    chk(32'(driverShutdown), 32'(m < 2));
    chk(32'(irq), 32'(m < 3));
    n = 0;
    while (driverShutdown !== 1'b0 && n < 100) begin
      @(posedge mclk);
      n++;
    end
    if (m == 2'h0) begin
      chk(32'(n), 32'd100);
      wr(GDC_ADDR_FAULT_CTRL, 32'h1);
      repeat (3) @(posedge mclk);
      chk(32'(driverShutdown), 32'h0);
    end else if (m == 2'h1) begin
      chk(32'(n >= wt - 4 && n <= wt), 32'h1);
    end
    rd(GDC_ADDR_IRQ_STATUS, {30'h0, m == 2'h1, m < 3});
    wr(GDC_ADDR_IRQ_MASK, 32'h0);
    repeat (2) @(posedge mclk);
    chk(32'(irq), 32'h0);
    wr(GDC_ADDR_IRQ_STATUS, 32'h3);
    rd(GDC_ADDR_IRQ_STATUS, 32'h0);
  endtask : t_oc
  // Overcurrent pulse while the clock enable is low must be missed entirely
  task automatic t_freeze;
    wr(GDC_ADDR_CFG_ONE, 32'h10228000);
    mclkEn <= 1'b0;
    ocDetectPin <= 1'b1;
    repeat (6) @(posedge mclk);
    chk(32'(driverShutdown), 32'h0);
    ocDetectPin <= 1'b0;
    repeat (4) @(posedge mclk);
    mclkEn <= 1'b1;
    repeat (6) @(posedge mclk);
    chk(32'(driverShutdown), 32'h0);
    rd(GDC_ADDR_IRQ_STATUS, 32'h0);
  endtask : t_freeze
  // Reset in mid-run restores both words, including the cleared sequencing bit
  task automatic t_mid_reset;
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    t_reset();
  endtask : t_mid_reset
  initial begin
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_cfg_one();
    t_cfg_two();
    t_unmapped();
    t_oc(2'h0, 1'b0, RS);
    t_oc(2'h1, 1'b0, RS);
    t_oc(2'h1, 1'b1, RL);
    t_oc(2'h2, 1'b0, RS);
    t_oc(2'h3, 1'b0, RS);
    t_freeze();
    t_mid_reset();
    give_verdict();
  end
endmodule : gdc_regs_test
bind gdc_regs gdc_regs_checker #(.RETRY_SHORT(RETRY_SHORT), .RETRY_LONG(RETRY_LONG))
  i_gdc_regs_checker (.mclk, .sys_rst, .mclkEn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .prdata, .pready, .pslverr, .ocDetectPin, .driverShutdown,
  .ocThresholdSel, .senseAmpGain, .delayCompEnable, .targetDelay, .regulatorSlewSel,
  .regulatorSequencingOff, .regulatorCurrentLimit, .regulatorVoltageSel, .regulatorDisable);
`default_nettype wire
